// ---- hdl/d2ct_pkg.sv ----
// d2ct_pkg: command codes, fsm states and timing figures for the ddr2 host timer.
// assumes a 125 MHz system clock; the memory clock is that clock divided by two.
package d2ct_pkg;

	localparam int T_SYS_PS = 8000;
	localparam int CK_SYS_CYC = 2;

	// smallest whole number of system cycles covering a time, never below one
	function automatic int cyc_up(input int t_ps);
		int c;
		c = (t_ps + T_SYS_PS - 1) / T_SYS_PS;
		return (c < 1) ? 1 : c;
	endfunction : cyc_up

	// largest whole number of system cycles inside a time, never below one
	function automatic int cyc_dn(input int t_ps);
		int c;
		c = t_ps / T_SYS_PS;
		return (c < 1) ? 1 : c;
	endfunction : cyc_dn

	////////////////////////////////////////////////////////////////////////////////
	localparam int WRITE_TO_READ_GAP_PS = 7500;
	localparam int WRITE_RECOVERY_TIME_PS = 15000;
	localparam int ROW_PRECHARGE_TIME_PS = 15000;
	localparam int ROW_PRECHARGE_TIME_FAST_PS = 12500;
	localparam int ROW_OPEN_TIME_MIN_PS = 45000;
	localparam int ROW_OPEN_TIME_MAX_NS = 70000;
	localparam int ROW_CYCLE_TIME_PS = 60000;
	localparam int ROW_CYCLE_TIME_FAST_PS = 57500;
	localparam int BANK_ACTIVATE_SPACING_PS = 10000;
	localparam int REFRESH_CYCLE_TIME_PS = 127500;
	localparam int ROW_TO_COLUMN_PS = 15000;
	localparam int ROW_TO_COLUMN_FAST_PS = 12500;

	localparam int WTR_CYC = cyc_up(WRITE_TO_READ_GAP_PS);
	localparam int WR_CYC = cyc_up(WRITE_RECOVERY_TIME_PS);
	localparam int RP_CYC = cyc_up(ROW_PRECHARGE_TIME_PS);
	localparam int RP_FAST_CYC = cyc_up(ROW_PRECHARGE_TIME_FAST_PS);
	localparam int RAS_MIN_CYC = cyc_up(ROW_OPEN_TIME_MIN_PS);
	localparam int RAS_MAX_CYC = cyc_dn(ROW_OPEN_TIME_MAX_NS * 1000);
	localparam int RC_CYC = cyc_up(ROW_CYCLE_TIME_PS);
	localparam int RC_FAST_CYC = cyc_up(ROW_CYCLE_TIME_FAST_PS);
	localparam int RRD_CYC = cyc_up(BANK_ACTIVATE_SPACING_PS);
	localparam int RFC_CYC = cyc_up(REFRESH_CYCLE_TIME_PS);
	localparam int RCD_CYC = cyc_up(ROW_TO_COLUMN_PS);
	localparam int RCD_FAST_CYC = cyc_up(ROW_TO_COLUMN_FAST_PS);

	// strobe figures in tenths of a memory clock period
	localparam int READ_PREAMBLE_MIN_T = 9;
	localparam int READ_PREAMBLE_MAX_T = 11;
	localparam int RPRE_MIN_CYC = (READ_PREAMBLE_MIN_T * CK_SYS_CYC) / 10;
	localparam int RPRE_MAX_CYC = (READ_PREAMBLE_MAX_T * CK_SYS_CYC + 9) / 10 + 1;
	localparam int WRITE_PREAMBLE_CYC = CK_SYS_CYC;
	localparam int BURST_BEATS = 4;
	localparam int READ_TIMEOUT_CYC = 64;

	////////////////////////////////////////////////////////////////////////////////
	typedef enum logic [2:0] {
		D2CT_NOP = 3'h0,
		D2CT_ACT = 3'h1,
		D2CT_RD = 3'h2,
		D2CT_WR = 3'h3,
		D2CT_WRA = 3'h4,
		D2CT_PRE = 3'h5,
		D2CT_REF = 3'h6
	} d2ct_cmd_type;

	typedef enum logic [2:0] {
		W_IDLE = 3'h0,
		W_LAT = 3'h1,
		W_PRE = 3'h2,
		W_DATA = 3'h3,
		W_POST = 3'h4
	} d2ct_wstate_type;

	typedef enum logic [1:0] {
		R_IDLE = 2'h0,
		R_WAIT = 2'h1,
		R_LOW = 2'h2,
		R_DATA = 2'h3
	} d2ct_rstate_type;

	// ras, cas, we levels per command
	localparam logic [2:0] PINS_NOP = 3'h7;
	localparam logic [2:0] PINS_ACT = 3'h3;
	localparam logic [2:0] PINS_RD = 3'h5;
	localparam logic [2:0] PINS_WR = 3'h4;
	localparam logic [2:0] PINS_PRE = 3'h2;
	localparam logic [2:0] PINS_REF = 3'h1;

endpackage : d2ct_pkg

// ---- hdl/d2ct_bank_timer.sv ----
// d2ct_bank_timer: per-bank row state and spacing counters for the ddr2 host.
// assumes single-cycle event pulses from the host scheduler on the same clock.
`timescale 1ns/1ps
`default_nettype none
module d2ct_bank_timer #(
	parameter int CW = 8,
	parameter int OW = 14,
	parameter int RAS_MAX = d2ct_pkg::RAS_MAX_CYC,
	parameter int RC = d2ct_pkg::RC_CYC,
	parameter int RP = d2ct_pkg::RP_CYC,
	parameter int RCD = d2ct_pkg::RCD_CYC
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic act_in,
	input wire logic pre_in,
	input wire logic wr_end_in,
	input wire logic wra_end_in,
	output logic open_out,
	output logic act_ok_out,
	output logic col_ok_out,
	output logic pre_ok_out,
	output logic expire_out
);
	logic [CW-1:0] rc_r;
	logic [CW-1:0] ras_r;
	logic [CW-1:0] rp_r;
	logic [CW-1:0] wr_r;
	logic [CW-1:0] rcd_r;
	logic [OW-1:0] age_r;
	logic open_r;

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			open_r <= 1'b0;
		end else if (ce_in) begin
			if (act_in) begin
				open_r <= 1'b1;
			end else if (pre_in || wra_end_in) begin
				open_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			rc_r <= '0;
		end else if (ce_in) begin
			if (act_in) begin
				rc_r <= CW'(RC);
			end else if (rc_r != '0) begin
				rc_r <= rc_r - CW'(1);
			end
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			ras_r <= '0;
			rcd_r <= '0;
		end else if (ce_in) begin
			if (act_in) begin
				ras_r <= CW'(d2ct_pkg::RAS_MIN_CYC);
				rcd_r <= CW'(RCD);
			end else begin
				if (ras_r != '0) begin
					ras_r <= ras_r - CW'(1);
				end
				if (rcd_r != '0) begin
					rcd_r <= rcd_r - CW'(1);
				end
			end
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			rp_r <= '0;
		end else if (ce_in) begin
			if (wra_end_in) begin
				rp_r <= CW'(d2ct_pkg::WR_CYC + RP);
			end else if (pre_in) begin
				rp_r <= CW'(RP);
			end else if (rp_r != '0) begin
				rp_r <= rp_r - CW'(1);
			end
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			wr_r <= '0;
		end else if (ce_in) begin
			if (wr_end_in) begin
				wr_r <= CW'(d2ct_pkg::WR_CYC);
			end else if (wr_r != '0) begin
				wr_r <= wr_r - CW'(1);
			end
		end
	end

	// row open age for the longest open time
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			age_r <= '0;
		end else if (ce_in) begin
			if (act_in || !open_r) begin
				age_r <= '0;
			end else if (age_r != OW'(RAS_MAX)) begin
				age_r <= age_r + OW'(1);
			end
		end
	end

	assign open_out = open_r;
	assign act_ok_out = !open_r && (rc_r == '0) && (rp_r == '0);
	assign col_ok_out = open_r && (rcd_r == '0);
	assign pre_ok_out = open_r && (ras_r == '0) && (wr_r == '0);
	// warn a few memory clocks early so the precharge lands inside the limit
	assign expire_out = open_r && (age_r >= OW'(RAS_MAX - 4 * d2ct_pkg::CK_SYS_CYC));
endmodule : d2ct_bank_timer
`default_nettype wire

// ---- hdl/d2ct_host.sv ----
// d2ct_host: ddr2 host that spaces commands and drives or samples the data strobe.
// assumes a 125 MHz clock, burst of four, device strobe line idles high when released.
//
// Operation
// - wait the write-to-read gap after last write data before a read
// - after write with autoprecharge, wait write recovery plus precharge before activate
// - write strobe preamble lasts at least 0.35 clock periods
// - write preamble held at least 0.25 clock periods from the clock edge
// - first rising write strobe within a quarter period of the rising clock
// - falling write strobe edges at least 0.2 periods from rising clock edges
// - row open at least 45 ns and at most 70K ns before precharge; host only raises row_expire_out, never closes the row
// - same-bank activates spaced by 60 ns, 57.5 ns for the fast grade
// - precharge to activate 15 ns, 12.5 ns for the fast grade
// - activates to different banks at least 10 ns apart
// - after refresh wait 127.5 ns before activate or refresh
// - write recovery 15 ns after last data before precharge
`timescale 1ns/1ps
`default_nettype none
module d2ct_host #(
	parameter int DW = 16,
	parameter int AW = 14,
	parameter int BANKS = 8,
	parameter int BW = 3,
	parameter int WLAT = 2,
	parameter bit FAST_GRADE = 1'b0,
	parameter int RAS_MAX_CYC = d2ct_pkg::RAS_MAX_CYC
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic req_valid_in,
	input wire logic [2:0] req_cmd_in,
	input wire logic [BW-1:0] req_bank_in,
	input wire logic [AW-1:0] req_addr_in,
	input wire logic [4*DW-1:0] req_wdata_in,
	output logic req_ready_out,
	output logic [4*DW-1:0] rdata_out,
	output logic rdata_valid_out,
	output logic preamble_err_out,
	output logic [BANKS-1:0] row_expire_out,
	output logic ck_out,
	output logic cs_n_out,
	output logic ras_n_out,
	output logic cas_n_out,
	output logic we_n_out,
	output logic [BW-1:0] ba_out,
	output logic [AW-1:0] addr_out,
	input wire logic [DW-1:0] dq_in,
	output logic [DW-1:0] dq_out,
	output logic dq_oe_out,
	input wire logic dqs_in,
	output logic dqs_out,
	output logic dqs_oe_out
);
	localparam int RC = FAST_GRADE ? d2ct_pkg::RC_FAST_CYC : d2ct_pkg::RC_CYC;
	localparam int RP = FAST_GRADE ? d2ct_pkg::RP_FAST_CYC : d2ct_pkg::RP_CYC;
	localparam int RCD = FAST_GRADE ? d2ct_pkg::RCD_FAST_CYC : d2ct_pkg::RCD_CYC;
	localparam int WLAT_LOAD = d2ct_pkg::CK_SYS_CYC * WLAT - d2ct_pkg::WRITE_PREAMBLE_CYC - 1;

	logic phase_r;
	logic [BANKS-1:0] open_w, act_ok_w, col_ok_w, pre_ok_w, expire_w;
	logic [BANKS-1:0] act_hit, pre_hit, wend_hit, waend_hit;
	logic [7:0] rrd_r, rfc_r, wtr_r;
	logic allow, take, wr_end, wauto_r;
	logic [BW-1:0] wbank_r;
	d2ct_pkg::d2ct_wstate_type wst_r;
	d2ct_pkg::d2ct_rstate_type rst_r;
	logic [7:0] wcnt_r, rcnt_r;
	logic [4*DW-1:0] wdata_r;
	logic dqs_s1_r, dqs_s2_r, dqs_s3_r;
	logic [DW-1:0] dq_s1_r, dq_s2_r;

	////////////////////////////////////////////////////////////////////////////////
	genvar g;
	generate
		for (g = 0; g < BANKS; g++) begin : g_bank
			assign act_hit[g] = take && (req_cmd_in == d2ct_pkg::D2CT_ACT) && (req_bank_in == BW'(g));
			assign pre_hit[g] = take && (req_cmd_in == d2ct_pkg::D2CT_PRE) && (req_bank_in == BW'(g));
			assign wend_hit[g] = wr_end && (wbank_r == BW'(g));
			assign waend_hit[g] = wr_end && wauto_r && (wbank_r == BW'(g));
			d2ct_bank_timer #(.RAS_MAX(RAS_MAX_CYC), .RC(RC), .RP(RP), .RCD(RCD)) u_bank (
				.clk_sys_in(clk_sys_in),
				.rst_in(rst_in),
				.ce_in(ce_in),
				.act_in(act_hit[g]),
				.pre_in(pre_hit[g]),
				.wr_end_in(wend_hit[g]),
				.wra_end_in(waend_hit[g]),
				.open_out(open_w[g]),
				.act_ok_out(act_ok_w[g]),
				.col_ok_out(col_ok_w[g]),
				.pre_ok_out(pre_ok_w[g]),
				.expire_out(expire_w[g])
			);
		end
	endgenerate
	assign row_expire_out = expire_w;

	////////////////////////////////////////////////////////////////////////////////
	// command admission; decided only on the low clock phase so each command
	// holds the pins for a full memory clock from one rising clock edge to the next
	always_comb begin
		allow = 1'b0;
		unique case (req_cmd_in)
			d2ct_pkg::D2CT_ACT: allow = act_ok_w[req_bank_in] && (rrd_r == '0) && (rfc_r == '0);
			d2ct_pkg::D2CT_RD: allow = col_ok_w[req_bank_in] && (wst_r == d2ct_pkg::W_IDLE)
				&& (rst_r == d2ct_pkg::R_IDLE) && (wtr_r == '0);
			d2ct_pkg::D2CT_WR, d2ct_pkg::D2CT_WRA: allow = col_ok_w[req_bank_in]
				&& (wst_r == d2ct_pkg::W_IDLE) && (rst_r == d2ct_pkg::R_IDLE);
			d2ct_pkg::D2CT_PRE: allow = pre_ok_w[req_bank_in] && (wst_r == d2ct_pkg::W_IDLE)
				&& (rst_r == d2ct_pkg::R_IDLE);
			d2ct_pkg::D2CT_REF: allow = (open_w == '0) && (&act_ok_w) && (rfc_r == '0);
			d2ct_pkg::D2CT_NOP: allow = 1'b1;
			default: allow = 1'b0;
		endcase
	end
	assign req_ready_out = ce_in && !phase_r && allow;
	assign take = req_valid_in && req_ready_out;

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			phase_r <= 1'b0;
		end else if (ce_in) begin
			phase_r <= !phase_r;
		end
	end
	assign ck_out = phase_r;

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			cs_n_out <= 1'b1;
			{ras_n_out, cas_n_out, we_n_out} <= d2ct_pkg::PINS_NOP;
			ba_out <= '0;
			addr_out <= '0;
		end else if (ce_in && !phase_r) begin
			cs_n_out <= !(take && req_cmd_in != d2ct_pkg::D2CT_NOP);
			ba_out <= req_bank_in;
			addr_out <= req_addr_in;
			{ras_n_out, cas_n_out, we_n_out} <= d2ct_pkg::PINS_NOP;
			if (take) begin
				unique case (req_cmd_in)
					d2ct_pkg::D2CT_ACT: {ras_n_out, cas_n_out, we_n_out} <= d2ct_pkg::PINS_ACT;
					d2ct_pkg::D2CT_RD: {ras_n_out, cas_n_out, we_n_out} <= d2ct_pkg::PINS_RD;
					d2ct_pkg::D2CT_WR: {ras_n_out, cas_n_out, we_n_out} <= d2ct_pkg::PINS_WR;
					d2ct_pkg::D2CT_WRA: {ras_n_out, cas_n_out, we_n_out} <= d2ct_pkg::PINS_WR;
					d2ct_pkg::D2CT_PRE: {ras_n_out, cas_n_out, we_n_out} <= d2ct_pkg::PINS_PRE;
					d2ct_pkg::D2CT_REF: {ras_n_out, cas_n_out, we_n_out} <= d2ct_pkg::PINS_REF;
					default: {ras_n_out, cas_n_out, we_n_out} <= d2ct_pkg::PINS_NOP;
				endcase
				// auto precharge rides on address bit ten
				if (req_cmd_in == d2ct_pkg::D2CT_WRA) begin
					addr_out[10] <= 1'b1;
				end else if (req_cmd_in == d2ct_pkg::D2CT_WR || req_cmd_in == d2ct_pkg::D2CT_RD) begin
					addr_out[10] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			rrd_r <= '0;
			rfc_r <= '0;
			wtr_r <= '0;
		end else if (ce_in) begin
			rrd_r <= (take && req_cmd_in == d2ct_pkg::D2CT_ACT) ? 8'(d2ct_pkg::RRD_CYC)
				: (rrd_r != '0) ? rrd_r - 8'h01 : rrd_r;
			rfc_r <= (take && req_cmd_in == d2ct_pkg::D2CT_REF) ? 8'(d2ct_pkg::RFC_CYC)
				: (rfc_r != '0) ? rfc_r - 8'h01 : rfc_r;
			wtr_r <= wr_end ? 8'(d2ct_pkg::WTR_CYC) : (wtr_r != '0) ? wtr_r - 8'h01 : wtr_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// write strobe: one full memory clock of low preamble, then strobe follows
	// the clock so its rises sit on clock rises and its falls mid-period
	assign wr_end = ce_in && (wst_r == d2ct_pkg::W_POST);

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			wst_r <= d2ct_pkg::W_IDLE;
			wcnt_r <= '0;
			wbank_r <= '0;
			wauto_r <= 1'b0;
			wdata_r <= '0;
			dq_out <= '0;
			dq_oe_out <= 1'b0;
			dqs_out <= 1'b0;
			dqs_oe_out <= 1'b0;
		end else if (ce_in) begin
			unique case (wst_r)
				d2ct_pkg::W_IDLE: begin
					if (take && (req_cmd_in == d2ct_pkg::D2CT_WR || req_cmd_in == d2ct_pkg::D2CT_WRA)) begin
						wst_r <= d2ct_pkg::W_LAT;
						wcnt_r <= 8'(WLAT_LOAD);
						wbank_r <= req_bank_in;
						wauto_r <= (req_cmd_in == d2ct_pkg::D2CT_WRA);
						wdata_r <= req_wdata_in;
					end
				end
				d2ct_pkg::W_LAT: begin
					wcnt_r <= wcnt_r - 8'h01;
					// preamble begins after the clock edge
					if (wcnt_r == '0) begin
						wst_r <= d2ct_pkg::W_PRE;
						wcnt_r <= 8'(d2ct_pkg::WRITE_PREAMBLE_CYC - 1);
						dqs_oe_out <= 1'b1;
						dqs_out <= 1'b0;
					end
				end
				d2ct_pkg::W_PRE: begin
					wcnt_r <= wcnt_r - 8'h01;
					if (wcnt_r == '0) begin
						wst_r <= d2ct_pkg::W_DATA;
						wcnt_r <= 8'(d2ct_pkg::BURST_BEATS - 1);
						// first rise on the clock rise
						dqs_out <= 1'b1;
						dq_oe_out <= 1'b1;
						dq_out <= wdata_r[DW-1:0];
						wdata_r <= wdata_r >> DW;
					end
				end
				d2ct_pkg::W_DATA: begin
					wcnt_r <= wcnt_r - 8'h01;
					dqs_out <= !dqs_out;
					dq_out <= wdata_r[DW-1:0];
					wdata_r <= wdata_r >> DW;
					if (wcnt_r == '0) begin
						wst_r <= d2ct_pkg::W_POST;
						dqs_out <= 1'b0;
						dq_oe_out <= 1'b0;
					end
				end
				d2ct_pkg::W_POST: begin
					wst_r <= d2ct_pkg::W_IDLE;
					dqs_oe_out <= 1'b0;
				end
				default: wst_r <= d2ct_pkg::W_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// strobe and data from the device are pins: two flops before any use
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			dqs_s1_r <= 1'b1;
			dqs_s2_r <= 1'b1;
			dqs_s3_r <= 1'b1;
			dq_s1_r <= '0;
			dq_s2_r <= '0;
		end else if (ce_in) begin
			dqs_s1_r <= dqs_in;
			dqs_s2_r <= dqs_s1_r;
			dqs_s3_r <= dqs_s2_r;
			dq_s1_r <= dq_in;
			dq_s2_r <= dq_s1_r;
		end
	end

	// read capture; sampling at the system clock limits this to a slow memory
	// clock, and the preamble check can only resolve whole system cycles
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			rst_r <= d2ct_pkg::R_IDLE;
			rcnt_r <= '0;
			rdata_out <= '0;
			rdata_valid_out <= 1'b0;
			preamble_err_out <= 1'b0;
		end else if (ce_in) begin
			rdata_valid_out <= 1'b0;
			unique case (rst_r)
				d2ct_pkg::R_IDLE: begin
					if (take && req_cmd_in == d2ct_pkg::D2CT_RD) begin
						rst_r <= d2ct_pkg::R_WAIT;
						rcnt_r <= 8'(d2ct_pkg::READ_TIMEOUT_CYC);
					end
				end
				d2ct_pkg::R_WAIT: begin
					rcnt_r <= rcnt_r - 8'h01;
					if (!dqs_s2_r) begin
						rst_r <= d2ct_pkg::R_LOW;
						rcnt_r <= 8'h01;
					end else if (rcnt_r == '0) begin
						rst_r <= d2ct_pkg::R_IDLE;
					end
				end
				d2ct_pkg::R_LOW: begin
					rcnt_r <= rcnt_r + 8'h01;
					if (dqs_s2_r) begin
						rst_r <= d2ct_pkg::R_DATA;
						preamble_err_out <= (rcnt_r < 8'(d2ct_pkg::RPRE_MIN_CYC))
							|| (rcnt_r > 8'(d2ct_pkg::RPRE_MAX_CYC));
						rdata_out <= {dq_s2_r, rdata_out[4*DW-1:DW]};
						rcnt_r <= 8'(d2ct_pkg::BURST_BEATS - 1);
					end else if (rcnt_r == 8'(d2ct_pkg::READ_TIMEOUT_CYC)) begin
						rst_r <= d2ct_pkg::R_IDLE;
						preamble_err_out <= 1'b1;
					end
				end
				d2ct_pkg::R_DATA: begin
					if (dqs_s2_r != dqs_s3_r) begin
						rdata_out <= {dq_s2_r, rdata_out[4*DW-1:DW]};
						rcnt_r <= rcnt_r - 8'h01;
						if (rcnt_r == 8'h01) begin
							rst_r <= d2ct_pkg::R_IDLE;
							rdata_valid_out <= 1'b1;
						end
					end
				end
				default: rst_r <= d2ct_pkg::R_IDLE;
			endcase
		end
	end
endmodule : d2ct_host
`default_nettype wire

// ---- sim/d2ct_host_checker.sv ----
// d2ct_host_checker: command spacing and write strobe assertions for d2ct_host.
// assumes it is bound to d2ct_host; counters saturate, so reset reads as a long idle.
`timescale 1ns/1ps
`default_nettype none
module d2ct_host_checker #(
	parameter int RAS_MAX_CYC = 64
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic ck_out,
	input wire logic cs_n_out,
	input wire logic ras_n_out,
	input wire logic cas_n_out,
	input wire logic we_n_out,
	input wire logic [2:0] ba_out,
	input wire logic [13:0] addr_out,
	input wire logic [7:0] row_expire_out,
	input wire logic dq_oe_out,
	input wire logic dqs_out,
	input wire logic dqs_oe_out
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	logic ph_r;
	logic nw;
	logic act;
	logic pre;
	logic refr;
	logic miss;
	logic wra_r;
	logic [2:0] wb_r;
	logic [2:0] pins;
	logic [7:0] open_r;
	logic [15:0] sr_r;
	logic [15:0] de_r;
	logic [15:0] sa_r [8];
	logic [15:0] sp_r [8];
	// pins stand two cycles, so only the first cycle of a command counts
	assign nw = !cs_n_out && !ph_r;
	assign pins = {ras_n_out, cas_n_out, we_n_out};
	assign act = nw && pins == d2ct_pkg::PINS_ACT;
	assign pre = nw && pins == d2ct_pkg::PINS_PRE;
	assign refr = nw && pins == d2ct_pkg::PINS_REF;
	function automatic logic [15:0] inc(input logic [15:0] v);
		return (v == 16'hFFFF) ? v : v + 16'h0001;
	endfunction : inc
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			ph_r <= 1'b0;
			wra_r <= 1'b0;
			wb_r <= 3'h0;
			open_r <= 8'h00;
			sr_r <= 16'hFFFF;
			de_r <= 16'hFFFF;
			for (int i = 0; i < 8; i++) begin
				sa_r[i] <= 16'hFFFF;
				sp_r[i] <= 16'hFFFF;
			end
		end else begin
			ph_r <= nw;
			sr_r <= refr ? 16'h0000 : inc(sr_r);
			de_r <= $fell(dq_oe_out) ? 16'h0000 : inc(de_r);
			if (nw && pins == d2ct_pkg::PINS_WR && addr_out[10]) begin
				wra_r <= 1'b1;
				wb_r <= ba_out;
			end else if (act && ba_out == wb_r) begin
				wra_r <= 1'b0;
			end
			for (int i = 0; i < 8; i++) begin
				sa_r[i] <= (act && ba_out == 3'(i)) ? 16'h0000 : inc(sa_r[i]);
				sp_r[i] <= (pre && ba_out == 3'(i)) ? 16'h0000 : inc(sp_r[i]);
				if (act && ba_out == 3'(i))
					open_r[i] <= 1'b1;
				else if (pre && ba_out == 3'(i))
					open_r[i] <= 1'b0;
			end
		end
	end
	always_comb begin
		miss = 1'b0;
		for (int i = 0; i < 8; i++)
			miss |= open_r[i] && sa_r[i] >= 16'(RAS_MAX_CYC - 6) && !row_expire_out[i]
				&& !(pre && ba_out == 3'(i));
	end
	////////////////////////////////////////
	// counters read gap minus one in the cycle of the new command
	// refresh cycle time
	refresh_gap_a: assert property ((act || refr) |-> sr_r >= 16'(d2ct_pkg::RFC_CYC - 1))
		else $error("command too soon after refresh");
	row_cycle_a: assert property (act |-> sa_r[ba_out] >= 16'(d2ct_pkg::RC_CYC - 1))
		else $error("same bank activate too soon");
	row_open_min_a: assert property (pre |-> sa_r[ba_out] >= 16'(d2ct_pkg::RAS_MIN_CYC - 1))
		else $error("row closed too early");
	row_expire_a: assert property (!miss)
		else $error("open row not flagged near its limit");
	pre_to_act_a: assert property (act |-> sp_r[ba_out] >= 16'(d2ct_pkg::RP_CYC - 1))
		else $error("activate too soon after precharge");
	wr_recovery_a: assert property (pre |-> de_r >= 16'(d2ct_pkg::WR_CYC - 1))
		else $error("precharge too soon after write data");
	wtr_gap_a: assert property ((nw && pins == d2ct_pkg::PINS_RD) |-> de_r >= 16'(d2ct_pkg::WTR_CYC - 1))
		else $error("read too soon after write data");
	dal_gap_a: assert property ((act && wra_r && ba_out == wb_r)
		|-> de_r >= 16'(d2ct_pkg::WR_CYC + d2ct_pkg::RP_CYC - 1))
		else $error("activate too soon after autoprecharge write");
	write_preamble_a: assert property ($rose(dqs_oe_out) |-> !dqs_out ##1 !dqs_out ##1 (dqs_out && dq_oe_out))
		else $error("write strobe preamble wrong");
	strobe_rise_a: assert property ($rose(dq_oe_out) |-> dqs_out && $rose(ck_out))
		else $error("first write strobe not with clock rise");
	strobe_fall_a: assert property ((dqs_oe_out && $fell(dqs_out)) |-> $fell(ck_out))
		else $error("write strobe fall near clock rise");
endmodule : d2ct_host_checker
bind d2ct_host d2ct_host_checker #(.RAS_MAX_CYC(RAS_MAX_CYC)) i_chk (.*);
`default_nettype wire

// ---- sim/d2ct_dev_model.sv ----
// d2ct_dev_model: behavioural device, stores one burst per bank and replays it on reads.
// assumes host pins on the same clock; the bench resolves the shared lines.
`timescale 1ns/1ps
`default_nettype none
module d2ct_dev_model #(
	parameter int CL = 6
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic cs_n_in,
	input wire logic ras_n_in,
	input wire logic cas_n_in,
	input wire logic we_n_in,
	input wire logic [2:0] ba_in,
	input wire logic [15:0] dq_in,
	input wire logic dq_oe_in,
	input wire logic long_pre_in,
	output logic [15:0] dq_out,
	output logic dqs_out,
	output logic oe_out
);
	logic ph_r;
	logic nw;
	logic [2:0] rb_r;
	logic [2:0] wk_r;
	logic [63:0] wb_r;
	logic [63:0] mem_r [8];
	int rt_r;
	int pl;
	int k;
	assign nw = !cs_n_in && !ph_r;
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			ph_r <= 1'b0;
			rt_r <= 255;
			rb_r <= 3'h0;
		end else begin
			ph_r <= nw;
			if (nw && {ras_n_in, cas_n_in, we_n_in} == d2ct_pkg::PINS_RD) begin
				rt_r <= 0;
				rb_r <= ba_in;
			end else if (rt_r < 255) begin
				rt_r <= rt_r + 1;
			end
		end
	end
	// beats shift in low first, so beat0 lands in the low lane
	always_ff @(posedge clk_sys_in) begin
		if (nw && {ras_n_in, cas_n_in, we_n_in} == d2ct_pkg::PINS_WR)
			wk_r <= ba_in;
		if (dq_oe_in)
			wb_r <= {dq_in, wb_r[63:16]};
		if ($fell(dq_oe_in))
			mem_r[wk_r] <= wb_r;
	end
	always_comb begin
		pl = long_pre_in ? 6 : 2;
		k = rt_r - CL - pl;
		oe_out = rt_r >= CL && rt_r <= CL + pl + 4;
		dqs_out = k >= 0 && k < 4 && !k[0];
		dq_out = mem_r[rb_r][16 * k[1:0] +: 16];
	end
endmodule : d2ct_dev_model
`default_nettype wire

// ---- sim/test_d2ct_host.sv ----
// test_d2ct_host: random bursts, spacing corners, bad preamble and row expiry.
// assumes d2ct_host with a shortened row limit and the behavioural device model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; \
	$display("Error %0t: value mismatch", $time); end end
module test_d2ct_host;
	localparam int RASM = 64;
	localparam int WL = 2;
	localparam logic [2:0] C_ACT = d2ct_pkg::D2CT_ACT;
	localparam logic [2:0] C_RD = d2ct_pkg::D2CT_RD;
	localparam logic [2:0] C_WR = d2ct_pkg::D2CT_WR;
	localparam logic [2:0] C_WRA = d2ct_pkg::D2CT_WRA;
	localparam logic [2:0] C_PRE = d2ct_pkg::D2CT_PRE;
	localparam logic [2:0] C_REF = d2ct_pkg::D2CT_REF;
	logic clk_sys_in = 1'b0;
	logic rst_in = 1'b1;
	logic req_valid_in = 1'b0;
	logic [2:0] req_cmd_in = 3'h0;
	logic [2:0] req_bank_in = 3'h0;
	logic [13:0] req_addr_in = 14'h0000;
	logic [63:0] req_wdata_in = 64'h0;
	logic long_pre = 1'b0;
	logic [15:0] dq_last = 16'h0000;
	wire logic [63:0] rdata_out;
	wire logic [7:0] row_expire_out;
	wire logic [2:0] ba_out;
	wire logic [13:0] addr_out;
	wire logic [15:0] dq_o, dev_dq, dq_in;
	wire logic req_ready_out, rdata_valid_out, preamble_err_out, ck_out, cs_n_out;
	wire logic ras_n_out, cas_n_out, we_n_out, dq_oe_out, dqs_o, dqs_oe_out, dev_dqs, dev_oe;
	wire logic dqs_in;
	int bad_count = 0;
	int checked = 0;
	int cyc = 0;
	int tk, ta, tw, tp;
	logic [63:0] d;
	logic [2:0] b;
	always #4 clk_sys_in = ~clk_sys_in;
	always @(posedge clk_sys_in) cyc <= cyc + 1;
	// released data line shows a changing pattern, strobe line is pulled up
	assign dq_in = dev_oe ? dev_dq : ~dq_last;
	always @(posedge clk_sys_in) dq_last <= dq_in;
	assign dqs_in = dqs_oe_out ? dqs_o : (dev_oe ? dev_dqs : 1'b1);
	d2ct_host #(.WLAT(WL), .RAS_MAX_CYC(RASM)) i_dut (.ce_in(1'b1), .dq_out(dq_o),
		.dqs_out(dqs_o), .*);
	d2ct_dev_model i_dev (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .cs_n_in(cs_n_out),
		.ras_n_in(ras_n_out), .cas_n_in(cas_n_out), .we_n_in(we_n_out), .ba_in(ba_out),
		.dq_in(dq_o), .dq_oe_in(dq_oe_out), .long_pre_in(long_pre), .dq_out(dev_dq),
		.dqs_out(dev_dqs), .oe_out(dev_oe));
	////////////////////////////////////////
	function automatic int need(input int ps);
		return (ps + 7999) / 8000;
	endfunction : need
	task automatic conclude;
		if (bad_count == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : conclude
	// request held from a falling edge until the rising edge that takes it
	task automatic issue(input logic [2:0] c, input logic [2:0] bk, input logic [63:0] w);
		int m;
		@(negedge clk_sys_in);
		req_valid_in = 1'b1;
		req_cmd_in = c;
		req_bank_in = bk;
		req_wdata_in = w;
		req_addr_in = {3'($urandom), 1'b0, 10'($urandom)};
		// ready is looked at settled, before the edge that takes the request
		for (m = 0; m < 500; m++) begin
			#2;
			if (req_ready_out === 1'b1)
				break;
			@(negedge clk_sys_in);
		end
		@(posedge clk_sys_in);
		if (m >= 500) begin
			bad_count++;
			$display("Error %0t: request not taken", $time);
		end
		tk = cyc;
		@(negedge clk_sys_in);
		req_valid_in = 1'b0;
	endtask : issue
	task automatic wait_valid;
		for (int m = 0; m < 200 && rdata_valid_out !== 1'b1; m++)
			@(posedge clk_sys_in);
	endtask : wait_valid
	////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge clk_sys_in);
		bad_count++;
		conclude();
	end
	initial begin
		void'($urandom(32'h05FA));
		repeat (20) @(posedge clk_sys_in);
		@(negedge clk_sys_in);
		rst_in = 1'b0;
		for (int i = 0; i < 6; i++) begin
			b = (i == 0) ? 3'h7 : 3'($urandom);
			d = (i == 1) ? 64'hFFFF_0000_FFFF_0000 : {$urandom, $urandom};
			issue(C_ACT, b, 64'h0);
			ta = tk;
			issue(C_WR, b, d);
			tw = tk;
			issue(C_RD, b, 64'h0);
			`CHK(tk - tw >= 2 * WL + 4 + need(7500), 1'b1)
			wait_valid();
			`CHK(rdata_out, d)
			issue(C_PRE, b, 64'h0);
			tp = tk;
			`CHK(tk - tw >= 2 * WL + 4 + need(15000), 1'b1)
			`CHK(tk - ta >= need(45000), 1'b1)
			issue(C_ACT, b, 64'h0);
			`CHK(tk - ta >= need(60000), 1'b1)
			`CHK(tk - tp >= need(15000), 1'b1)
			d = ~d;
			issue(C_WRA, b, d);
			tw = tk;
			issue(C_ACT, b, 64'h0);
			`CHK(tk - tw >= 2 * WL + 4 + 2 * need(15000), 1'b1)
			issue(C_RD, b, 64'h0);
			wait_valid();
			`CHK(rdata_out, d)
			issue(C_PRE, b, 64'h0);
		end
		issue(C_ACT, 3'h0, 64'h0);
		ta = tk;
		issue(C_ACT, 3'h1, 64'h0);
		`CHK(tk - ta >= need(10000), 1'b1)
		issue(C_PRE, 3'h0, 64'h0);
		issue(C_PRE, 3'h1, 64'h0);
		issue(C_REF, 3'h0, 64'h0);
		ta = tk;
		issue(C_REF, 3'h0, 64'h0);
		`CHK(tk - ta >= need(127500), 1'b1)
		ta = tk;
		issue(C_ACT, 3'h3, 64'h0);
		`CHK(tk - ta >= need(127500), 1'b1)
		ta = tk;
		long_pre = 1'b1;
		issue(C_RD, 3'h3, 64'h0);
		for (int m = 0; m < 100 && preamble_err_out !== 1'b1; m++)
			@(posedge clk_sys_in);
		`CHK(preamble_err_out, 1'b1)
		wait_valid();
		@(negedge clk_sys_in);
		long_pre = 1'b0;
		issue(C_RD, 3'h3, 64'h0);
		wait_valid();
		@(negedge clk_sys_in);
		`CHK(preamble_err_out, 1'b0)
		while (row_expire_out[3] !== 1'b1 && cyc - ta < RASM)
			@(posedge clk_sys_in);
		`CHK(row_expire_out[3], 1'b1)
		`CHK(cyc - ta >= RASM - 12, 1'b1)
		issue(C_PRE, 3'h3, 64'h0);
		repeat (4) @(posedge clk_sys_in);
		`CHK(row_expire_out[3], 1'b0)
		conclude();
	end
endmodule : test_d2ct_host
`default_nettype wire
